/* File: hdl/pdt_timer.v */
// Top of the two-channel programmable down timer with register port and output pins
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_defs.vh"

// Function
// - Run/stop takes effect on input clock edge.
// - Stop happens at the next decrement.
// - Run bit reads one until really stopped.
// - Event mode: no edge, no run change.
// - Pulse output gated asynchronously by enable.
// - Fast oscillator off after reset.
// - Shared pin feeds port logic and timer.
// - Data zero forces pin steadily low.
// - Hiz one floats pin regardless.
// - Factor flags set even when masked.
// - Write one clears; unmasked set flag keeps requesting.
module pdt_timer #(
	parameter FAST_SETTLE_CYCLES = `PDT_FAST_SETTLE_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Register port
	input wire [3:0] regAddr,
	input wire [7:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regReadData,
	// Interrupt
	output wire irq,
	// Shared event clock pin and its copy to the input port logic
	input wire sharedEventClockPin,
	output wire sharedPinLevel,
	// Special output pin A
	output wire pinAOut,
	output wire pinAOutEnN,
	// Special output pin B
	output wire pinBOut,
	output wire pinBOutEnN,
	// Fast oscillator enable toward the clock generator
	output wire fastOscillatorOn
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg [7:0] ctrl;
	reg [3:0] clkSel;
	reg [7:0] reload0;
	reg [7:0] reload1;
	reg [3:0] pins;
	reg [2:0] status;
	reg [2:0] mask;
	reg [3:0] highCapture0;
	reg [3:0] highCapture1;
	reg [11:0] slowDiv;
	reg [11:0] fastDiv;
	reg slowTick;
	reg fastTick;
	reg [22:0] settleCount;
	reg fastReady;
	reg pinPrev;
	reg pulseToggle;
	reg pulseSlow;
	reg [7:0] next_readData;
	wire pinSync;
	wire eventTick;
	wire tick0;
	wire tick1;
	wire [7:0] count0;
	wire [7:0] count1;
	wire running0;
	wire running1;
	wire underflow0;
	wire underflow1;
	wire writeCtrl;
	wire writePreset;
	wire writeStatus;
	wire timerPulseSignal;
	wire specialA;
	wire specialB;
	wire [2:0] events;

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	assign writeCtrl = regWrite && (regAddr == `PDT_ADDR_CTRL);
	assign writePreset = regWrite && (regAddr == `PDT_ADDR_PRESET);
	assign writeStatus = regWrite && (regAddr == `PDT_ADDR_STATUS);

	// Software-written control registers
	always @(posedge clk) begin
		if (reset) begin
			ctrl <= `PDT_RST_CTRL;
			clkSel <= `PDT_RST_CLKSEL;
			reload0 <= `PDT_RST_RELOAD;
			reload1 <= `PDT_RST_RELOAD;
			pins <= `PDT_RST_PINS;
			mask <= `PDT_RST_MASK;
		end else if (regWrite) begin
			case (regAddr)
				`PDT_ADDR_CTRL: ctrl <= {1'b0, 1'b0, regWriteData[5:0]};
				`PDT_ADDR_CLKSEL: clkSel <= regWriteData[3:0];
				`PDT_ADDR_RELOAD0: reload0 <= regWriteData;
				`PDT_ADDR_RELOAD1: reload1 <= regWriteData;
				`PDT_ADDR_PINS: pins <= regWriteData[3:0];
				`PDT_ADDR_MASK: mask <= regWriteData[2:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------

	// Slow oscillator tick, derived from the system clock
	always @(posedge clk) begin
		if (reset) begin
			slowDiv <= 12'h000;
			slowTick <= 1'b0;
		end else if (slowDiv == `PDT_SLOW_DIV - 12'h001) begin
			slowDiv <= 12'h000;
			slowTick <= 1'b1;
		end else begin
			slowDiv <= slowDiv + 12'h001;
			slowTick <= 1'b0;
		end
	end

	// Fast oscillator settle timer; ticks stay off until it has run out
	// so a channel never counts on an unstable source.
	always @(posedge clk) begin
		if (reset || !ctrl[`PDT_CTRL_FAST_ON]) begin
			settleCount <= 23'h000000;
			fastReady <= 1'b0;
		end else if (settleCount == FAST_SETTLE_CYCLES[22:0] - 23'h000001) begin
			fastReady <= 1'b1;
		end else begin
			settleCount <= settleCount + 23'h000001;
		end
	end

	// Fast oscillator tick, only while the oscillator is on and settled
	always @(posedge clk) begin
		if (reset || !fastReady) begin
			fastDiv <= 12'h000;
			fastTick <= 1'b0;
		end else if (fastDiv == `PDT_FAST_DIV - 12'h001) begin
			fastDiv <= 12'h000;
			fastTick <= 1'b1;
		end else begin
			fastDiv <= fastDiv + 12'h001;
			fastTick <= 1'b0;
		end
	end

	assign fastOscillatorOn = ctrl[`PDT_CTRL_FAST_ON];

	// Shared pin synchroniser; the edge detector reads only the second stage
	pdt_sync pinSyncer (
		.clk(clk),
		.reset(reset),
		.asyncIn(sharedEventClockPin),
		.syncOut(pinSync)
	);

	always @(posedge clk) begin
		if (reset) begin
			pinPrev <= 1'b1;
		end else begin
			pinPrev <= pinSync;
		end
	end

	// Falling edge of the event clock counts; the port logic sees it too
	assign eventTick = pinPrev && !pinSync;
	assign sharedPinLevel = pinSync;

	// Per-channel source choice; an unused code selects no clock
	assign tick0 = (clkSel[1:0] == `PDT_SRC_SLOW) ? slowTick :
		(clkSel[1:0] == `PDT_SRC_FAST) ? fastTick :
		(clkSel[1:0] == `PDT_SRC_EVENT) ? eventTick : 1'b0;
	assign tick1 = (clkSel[3:2] == `PDT_SRC_SLOW) ? slowTick :
		(clkSel[3:2] == `PDT_SRC_FAST) ? fastTick :
		(clkSel[3:2] == `PDT_SRC_EVENT) ? eventTick : 1'b0;

	// ----------------------------------------------------------------
	// Counter channels
	// ----------------------------------------------------------------
	pdt_channel channel0 (
		.clk(clk),
		.reset(reset),
		.tick(tick0),
		.runReq(ctrl[`PDT_CTRL_RUN0]),
		.presetLoad(writePreset && regWriteData[0]),
		.reloadValue(reload0),
		.count(count0),
		.running(running0),
		.underflow(underflow0)
	);

	pdt_channel channel1 (
		.clk(clk),
		.reset(reset),
		.tick(tick1),
		.runReq(ctrl[`PDT_CTRL_RUN1]),
		.presetLoad(writePreset && regWriteData[1]),
		.reloadValue(reload1),
		.count(count1),
		.running(running1),
		.underflow(underflow1)
	);

	// ----------------------------------------------------------------
	// Pulse output and special pins
	// ----------------------------------------------------------------

	// Pulse toggles on each channel 0 underflow
	always @(posedge clk) begin
		if (reset) begin
			pulseToggle <= 1'b0;
		end else if (underflow0) begin
			pulseToggle <= ~pulseToggle;
		end
	end

	// Plain gate, not resynchronised: turning it on or off can clip the
	// running half-period, which software must tolerate.
	assign timerPulseSignal = pulseToggle & ctrl[`PDT_CTRL_PULSE_EN];

	// Pin A carries the timer pulse, pin B the slow clock divided by two
	assign specialA = ctrl[`PDT_CTRL_SPECIAL_A] ? timerPulseSignal : 1'b1;
	assign specialB = ctrl[`PDT_CTRL_SPECIAL_B] ? pulseSlow : 1'b1;

	// Slow clock divided by two for pin B
	always @(posedge clk) begin
		if (reset) begin
			pulseSlow <= 1'b0;
		end else if (slowTick) begin
			pulseSlow <= ~pulseSlow;
		end
	end

	// Data zero forces low; hiz one releases the pin
	assign pinAOut = pins[`PDT_PINS_A_DATA] & specialA;
	assign pinBOut = pins[`PDT_PINS_B_DATA] & specialB;
	assign pinAOutEnN = pins[`PDT_PINS_A_HIZ];
	assign pinBOutEnN = pins[`PDT_PINS_B_HIZ];

	// ----------------------------------------------------------------
	// Interrupt factor flags
	// ----------------------------------------------------------------
	assign events = {eventTick, underflow1, underflow0};

	// Events set regardless of mask; a new event beats a clearing write
	always @(posedge clk) begin
		if (reset) begin
			status <= 3'h0;
		end else begin
			status <= (status & ~(writeStatus ? regWriteData[2:0] : 3'h0)) | events;
		end
	end

	// Level request stays while any unmasked flag is left set
	assign irq = |(status & mask);

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------

	// Low nibble read freezes the high nibble for the following read
	always @(posedge clk) begin
		if (reset) begin
			highCapture0 <= 4'h0;
			highCapture1 <= 4'h0;
		end else if (regRead) begin
			if (regAddr == `PDT_ADDR_CNT0_LO) begin
				highCapture0 <= count0[7:4];
			end
			if (regAddr == `PDT_ADDR_CNT1_LO) begin
				highCapture1 <= count1[7:4];
			end
		end
	end

	// Read mux; run bits show request or still-running, unmapped reads zero
	always @* begin
		next_readData = 8'h00;
		case (regAddr)
			`PDT_ADDR_CTRL: begin
				next_readData = {fastReady, 1'b0, ctrl[5:2],
					ctrl[`PDT_CTRL_RUN1] | running1,
					ctrl[`PDT_CTRL_RUN0] | running0};
			end
			`PDT_ADDR_CLKSEL: next_readData = {4'h0, clkSel};
			`PDT_ADDR_RELOAD0: next_readData = reload0;
			`PDT_ADDR_RELOAD1: next_readData = reload1;
			`PDT_ADDR_CNT0_LO: next_readData = {4'h0, count0[3:0]};
			`PDT_ADDR_CNT0_HI: next_readData = {4'h0, highCapture0};
			`PDT_ADDR_CNT1_LO: next_readData = {4'h0, count1[3:0]};
			`PDT_ADDR_CNT1_HI: next_readData = {4'h0, highCapture1};
			`PDT_ADDR_PINS: next_readData = {4'h0, pins};
			`PDT_ADDR_STATUS: next_readData = {5'h00, status};
			`PDT_ADDR_MASK: next_readData = {5'h00, mask};
			default: next_readData = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (reset) begin
			regReadData <= 8'h00;
		end else if (regRead) begin
			regReadData <= next_readData;
		end else begin
			regReadData <= 8'h00;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/pdt_defs.vh */
// Register map, field positions, reset values and timing for the programmable down timer
`ifndef PDT_DEFS_VH
`define PDT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (4-bit address, 8-bit data)
// ----------------------------------------------------------------
`define PDT_ADDR_CTRL 4'h0
`define PDT_ADDR_CLKSEL 4'h1
`define PDT_ADDR_RELOAD0 4'h2
`define PDT_ADDR_RELOAD1 4'h3
`define PDT_ADDR_PRESET 4'h4
`define PDT_ADDR_CNT0_LO 4'h5
`define PDT_ADDR_CNT0_HI 4'h6
`define PDT_ADDR_CNT1_LO 4'h7
`define PDT_ADDR_CNT1_HI 4'h8
`define PDT_ADDR_PINS 4'h9
`define PDT_ADDR_STATUS 4'ha
`define PDT_ADDR_MASK 4'hb

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDT_CTRL_RUN0 0
`define PDT_CTRL_RUN1 1
`define PDT_CTRL_PULSE_EN 2
`define PDT_CTRL_FAST_ON 3
`define PDT_CTRL_SPECIAL_A 4
`define PDT_CTRL_SPECIAL_B 5
`define PDT_CTRL_FAST_READY 7
`define PDT_PINS_A_DATA 0
`define PDT_PINS_B_DATA 1
`define PDT_PINS_A_HIZ 2
`define PDT_PINS_B_HIZ 3
`define PDT_STAT_UF0 0
`define PDT_STAT_UF1 1
`define PDT_STAT_PIN 2
`define PDT_SRC_SLOW 2'h0
`define PDT_SRC_FAST 2'h1
`define PDT_SRC_EVENT 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDT_RST_CTRL 8'h00
`define PDT_RST_CLKSEL 4'h0
`define PDT_RST_RELOAD 8'hff
`define PDT_RST_PINS 4'hc
`define PDT_RST_MASK 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PDT_CLK_MHZ 100
`define PDT_FAST_SETTLE_US 5000
`define PDT_FAST_SETTLE_CYCLES (`PDT_FAST_SETTLE_US * `PDT_CLK_MHZ)
`define PDT_READ_WINDOW_US 730
`define PDT_SLOW_DIV 12'd3052
`define PDT_FAST_DIV 12'd25

`endif

/* File: hdl/pdt_sync.v */
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module pdt_sync (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Level in and out
	input wire asyncIn,
	output reg syncOut
);

	reg stage1;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (reset) begin
			stage1 <= 1'b1;
			syncOut <= 1'b1;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/pdt_channel.v */
// One 8-bit down-counting timer channel with synchronised run/stop
`timescale 1ns/1ps
`default_nettype none
`include "pdt_defs.vh"

module pdt_channel (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Control
	input wire tick,
	input wire runReq,
	input wire presetLoad,
	input wire [7:0] reloadValue,
	// Status
	output reg [7:0] count,
	output reg running,
	output reg underflow
);

	// Run state changes only on the input clock edge, never on the write
	always @(posedge clk) begin
		if (reset) begin
			count <= `PDT_RST_RELOAD;
			running <= 1'b0;
			underflow <= 1'b0;
		end else begin
			underflow <= 1'b0;
			if (presetLoad) begin
				count <= reloadValue;
			end else if (tick && running) begin
				if (count == 8'h00) begin
					count <= reloadValue;
					underflow <= 1'b1;
				end else begin
					count <= count - 8'h01;
				end
			end
			// Stop lands on the decrement edge; start on the next edge
			if (tick) begin
				running <= runReq;
			end
		end
	end

endmodule

`default_nettype wire

/* File: verification/pdt_timer_props.sv */
// Port assertions for the programmable down timer
`timescale 1ns/1ps
`default_nettype none

module pdt_timer_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regReadData,
	// Interrupt and pins
	input wire logic irq,
	input wire logic sharedEventClockPin,
	input wire logic sharedPinLevel,
	input wire logic pinAOut,
	input wire logic pinAOutEnN,
	input wire logic pinBOut,
	input wire logic pinBOutEnN,
	input wire logic fastOscillatorOn
);
	// ----------------------------------------
	// Decoded writes
	// ----------------------------------------
	// One clock domain, so clocking and disable are shared
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire wCtrl = regWrite && regAddr == 4'h0;
	wire wPins = regWrite && regAddr == 4'h9;

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_rst;
		$past(reset) |-> !fastOscillatorOn && !irq && pinAOutEnN && pinBOutEnN;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not at reset level");
	property p_osc;
		wCtrl |=> fastOscillatorOn == $past(regWriteData[3]);
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator enable wrong");
	property p_hiz;
		wPins |=> pinAOutEnN == $past(regWriteData[2]) && pinBOutEnN == $past(regWriteData[3]);
	endproperty
	a_hiz: assert property (p_hiz) else $error("pin float control wrong");
	property p_low;
		wPins && !regWriteData[0] |=> !pinAOut;
	endproperty
	a_low: assert property (p_low) else $error("pin not forced low");
	property p_gate;
		wCtrl && regWriteData[4] && !regWriteData[2] |=> !pinAOut;
	endproperty
	a_gate: assert property (p_gate) else $error("pulse not gated off");
	property p_sync;
		sharedPinLevel == $past(sharedEventClockPin, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("pin copy not two cycles late");
	property p_irq;
		irq && !regWrite |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt dropped");
	property p_mask;
		regWrite && regAddr == 4'hb && regWriteData == 8'h00 |=> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked flag raised irq");

	// Main scenarios reached
	c_irq: cover property ($rose(irq));
	c_pulse: cover property ($rose(pinAOut));
	c_edge: cover property ($fell(sharedPinLevel));
endmodule

`default_nettype wire

/* File: verification/pdt_event_src.sv */
// Event clock source model on the shared timer input pin
`timescale 1ns/1ps
`default_nettype none

module pdt_event_src (
	// Clock
	input wire logic clk,
	// One-cycle request for one low pulse
	input wire logic fire,
	// Pin, pulled high while idle
	output var logic pin
);
	int n = 0;

	// Low for four cycles, then back to the pull-up level
	always @(posedge clk) begin
		if (fire) begin
			n <= 4;
		end else if (n > 0) begin
			n <= n - 1;
		end
		pin <= !(fire || n > 1);
	end
endmodule

`default_nettype wire

/* File: verification/pdt_timer_tb_top.sv */
// Self-checking bench for the programmable down timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %0t: got %h expected %h", $time, a, e); end end

module pdt_timer_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWriteData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic fire = 1'b0;
	logic seen;
	wire logic [7:0] regReadData;
	wire logic irq, pin, sharedPinLevel, pinAOut, pinAOutEnN, pinBOut, pinBOutEnN;
	wire logic fastOscillatorOn;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	// Script rows: bit 12 write, then address, then data or expected read
	logic [12:0] rows [15] = '{13'h0000, 13'h0100, 13'h02ff, 13'h03ff, 13'h090c,
		13'h0b00, 13'h0f00, 13'h1f55, 13'h0f00, 13'h1b07, 13'h0b07, 13'h1b00,
		13'h1203, 13'h0203, 13'h0a00};

	// Short settle count keeps the fast source quick
	pdt_timer #(.FAST_SETTLE_CYCLES(20)) uut (.clk, .reset, .regAddr, .regWriteData,
		.regWrite, .regRead, .regReadData, .irq, .sharedEventClockPin(pin),
		.sharedPinLevel, .pinAOut, .pinAOutEnN, .pinBOut, .pinBOutEnN, .fastOscillatorOn);
	pdt_event_src src (.clk, .fire, .pin);

	// ----------------------------------------
	// Bus and pin tasks
	// ----------------------------------------
	// Each task ends at least one edge after dropping its strobe, so strobes never rewrite in a step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 `CHK(regReadData, e)
		@(posedge clk);
	endtask
	// Pulse plus three cycles of edge detection fits in twelve
	task automatic ev();
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (12) @(posedge clk);
	endtask
	task automatic results();
		$display("Checks %0d, errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i][12]) wr(rows[i][11:8], rows[i][7:0]);
			else rd(rows[i][11:8], rows[i][7:0]);
		end
		// Split read: a later load must not disturb the captured high nibble
		wr(4'h2, 8'h5a);
		wr(4'h4, 8'h01);
		rd(4'h5, 8'h0a);
		wr(4'h2, 8'hc3);
		wr(4'h4, 8'h01);
		rd(4'h6, 8'h05);
		rd(4'h5, 8'h03);
		rd(4'h6, 8'h0c);
		// Channel 1 counts pin events; ticks only come from the model
		wr(4'h1, 8'h0b);
		wr(4'h3, 8'h01);
		wr(4'h4, 8'h02);
		wr(4'h0, 8'h02);
		repeat (20) @(posedge clk);
		rd(4'h7, 8'h01);
		ev();
		rd(4'h7, 8'h01);
		ev();
		rd(4'h7, 8'h00);
		ev();
		rd(4'h7, 8'h01);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h02);
		repeat (20) @(posedge clk);
		rd(4'h7, 8'h01);
		ev();
		rd(4'h7, 8'h00);
		rd(4'h0, 8'h00);
		ev();
		rd(4'h7, 8'h00);
		rd(4'ha, 8'h06);
		`CHK(irq, 1'b0)
		wr(4'hb, 8'h02);
		`CHK(irq, 1'b1)
		wr(4'ha, 8'h02);
		`CHK(irq, 1'b0)
		rd(4'ha, 8'h04);
		// Channel 0 on the fast source drives the pulse onto pin A
		wr(4'h1, 8'h0d);
		wr(4'h2, 8'h01);
		wr(4'h4, 8'h01);
		wr(4'h9, 8'h01);
		wr(4'h0, 8'h08);
		`CHK(fastOscillatorOn, 1'b1)
		repeat (30) @(posedge clk);
		wr(4'h0, 8'h1d);
		seen = 1'b0;
		repeat (200) begin
			@(posedge clk);
			if (pinAOut === 1'b1) seen = 1'b1;
		end
		`CHK(seen, 1'b1)
		rd(4'h0, 8'h9d);
		wr(4'hb, 8'h01);
		`CHK(irq, 1'b1)
		wr(4'ha, 8'h07);
		repeat (60) @(posedge clk);
		`CHK(irq, 1'b1)
		wr(4'h0, 8'h19);
		wr(4'h9, 8'h00);
		`CHK(pinAOut, 1'b0)
		`CHK(pinBOut, 1'b0)
		// Pulse running again: data zero must still hold pin A low
		wr(4'h0, 8'h1d);
		seen = 1'b0;
		repeat (100) begin
			@(posedge clk);
			if (pinAOut !== 1'b0) seen = 1'b1;
		end
		`CHK(seen, 1'b0)
		wr(4'h9, 8'h0d);
		`CHK(pinAOutEnN, 1'b1)
		`CHK(pinBOutEnN, 1'b1)
		// Second reset in mid-run
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK(fastOscillatorOn, 1'b0)
		results();
	end
endmodule

bind pdt_timer pdt_timer_props chk (.clk, .reset, .regAddr, .regWriteData, .regWrite,
	.regRead, .regReadData, .irq, .sharedEventClockPin, .sharedPinLevel, .pinAOut,
	.pinAOutEnN, .pinBOut, .pinBOutEnN, .fastOscillatorOn);

`default_nettype wire
